// file: core/swtc_pkg.sv
package swtc_pkg;
	localparam int unsigned SWTC_CLK_HZ = 50000000;
	// Status word bit positions
	localparam int unsigned SWTC_N_POS = 31;
	localparam int unsigned SWTC_Z_POS = 30;
	localparam int unsigned SWTC_C_POS = 29;
	localparam int unsigned SWTC_V_POS = 28;
	localparam int unsigned SWTC_I_POS = 7;
	localparam int unsigned SWTC_F_POS = 6;
	localparam int unsigned SWTC_T_POS = 5;
	localparam logic [31:0] SWTC_DEF_MASK = 32'hf00000ff;
	localparam logic [31:0] SWTC_FLG_MASK = 32'hf0000000;
	localparam logic [31:0] SWTC_CTL_MASK = 32'h000000ff;
	localparam logic [31:0] SWTC_CURRENT_PROGRAM_STATUS_RST = 32'h000000d3;
	localparam logic [31:0] SWTC_SAVED_PROGRAM_STATUS_RST = 32'h00000000;
	// Mode field codes
	localparam logic [4:0] SWTC_M_USR = 5'h10;
	localparam logic [4:0] SWTC_M_FIQ = 5'h11;
	localparam logic [4:0] SWTC_M_IRQ = 5'h12;
	localparam logic [4:0] SWTC_M_SVC = 5'h13;
	localparam logic [4:0] SWTC_M_ABT = 5'h17;
	localparam logic [4:0] SWTC_M_UND = 5'h1b;
	localparam logic [4:0] SWTC_M_SYS = 5'h1f;
	// Saved-status bank indices
	localparam logic [2:0] SWTC_BK_FIQ = 3'h0;
	localparam logic [2:0] SWTC_BK_IRQ = 3'h1;
	localparam logic [2:0] SWTC_BK_SVC = 3'h2;
	localparam logic [2:0] SWTC_BK_ABT = 3'h3;
	localparam logic [2:0] SWTC_BK_UND = 3'h4;
	localparam logic [2:0] SWTC_BK_NONE = 3'h7;
	localparam int unsigned SWTC_NBANK = 5;
	// Opcodes
	localparam logic [3:0] SWTC_OP_TST = 4'h8;
	localparam logic [3:0] SWTC_OP_TEQ = 4'h9;
	localparam logic [3:0] SWTC_OP_CMP = 4'ha;
	localparam logic [3:0] SWTC_OP_CMN = 4'hb;
	localparam logic [3:0] SWTC_RD_PC = 4'hf;
	// Cycle counts per instruction class
	localparam logic [2:0] SWTC_CYC_NORM = 3'h1;
	localparam logic [2:0] SWTC_CYC_REGSH = 3'h2;
	localparam logic [2:0] SWTC_CYC_PC = 3'h3;
	localparam logic [2:0] SWTC_CYC_PC_REGSH = 3'h4;
	localparam logic [2:0] SWTC_CYC_PSR = 3'h1;
	typedef enum logic [1:0] {
		SWTC_KIND_S,
		SWTC_KIND_N,
		SWTC_KIND_I
	} swtc_cycle_type;
	typedef enum logic [2:0] {
		SWTC_CL_NOP,
		SWTC_CL_FLAG,
		SWTC_CL_DP,
		SWTC_CL_MRS,
		SWTC_CL_MSR_ALL,
		SWTC_CL_MSR_FLG
	} swtc_class_type;
endpackage

// file: core/swtc_cond.sv
`timescale 1ns/1ps
// Condition field evaluation against the current flags
module swtc_cond
	import swtc_pkg::*;
(
	input wire logic [3:0] cond,
	input wire logic [3:0] flags,
	output logic pass
);
	logic n, z, c, v;
	always_comb begin
		n = flags[3];
		z = flags[2];
		c = flags[1];
		v = flags[0];
		case (cond)
			4'h0: pass = z;
			4'h1: pass = !z;
			4'h2: pass = c;
			4'h3: pass = !c;
			4'h4: pass = n;
			4'h5: pass = !n;
			4'h6: pass = v;
			4'h7: pass = !v;
			4'h8: pass = c && !z;
			4'h9: pass = !c || z;
			4'ha: pass = n == v;
			4'hb: pass = n != v;
			4'hc: pass = !z && (n == v);
			4'hd: pass = z || (n != v);
			4'he: pass = 1'b1;
			default: pass = 1'b0;
		endcase
	end
endmodule

// file: core/swtc_core.sv
`timescale 1ns/1ps
// What this block does
// - Flag-only ops set flags, write no register
// - Legacy restore test copies saved word if in a banked mode
// - Normal 1S; register shift 1S plus 1I
// - PC written 2S+1N; register shift adds 1I
// - Status read copies full 32-bit word
// - Full status write moves register to word
// - Flags-only write sets bits 31:28 only
// - User mode writes flags only; privileged all
// - Saved word bank follows current mode
// - Twelve defined status bits, rest reserved
// - Every status transfer takes one sequential cycle
// - Test opcodes with S clear are transfers
// - Transfer runs only when condition passes
// - Non-test PC destination with S restores saved word in banked modes
module swtc_core
	import swtc_pkg::*;
#(
	parameter int unsigned NBANK = SWTC_NBANK
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic instr_valid,
	input wire logic [31:0] instr,
	input wire logic [31:0] operand,
	input wire logic [3:0] alu_flags,
	input wire logic [31:0] alu_result,
	output logic instr_ready,
	output logic [31:0] current_status_word,
	output logic [31:0] saved_status_word,
	output logic [31:0] reg_wdata,
	output logic [3:0] reg_waddr,
	output logic reg_we,
	output logic pc_we,
	output logic [31:0] pc_wdata,
	output logic cycle_valid,
	output swtc_cycle_type cycle_kind
);
	initial begin
		if (NBANK != SWTC_NBANK) begin
			$error("swtc_core: NBANK must equal five banks");
		end
	end

	logic [31:0] current_program_status_r, current_program_status_nxt;
	logic [31:0] saved_program_status_r [NBANK];
	logic [31:0] saved_program_status_nxt [NBANK];
	logic [31:0] rdata_r, rdata_nxt, pcd_r, pcd_nxt;
	logic [31:0] saved_program_status_view_r, saved_program_status_view_nxt;
	logic [3:0] waddr_r, waddr_nxt;
	logic we_r, we_nxt, pcwe_r, pcwe_nxt;
	logic [2:0] cyc_r, cyc_nxt;
	logic [2:0] pos_r, pos_nxt;
	logic [1:0] kind_r, kind_nxt;
	logic busy_r, busy_nxt;
	logic ready_r;
	logic cval_r, cval_nxt;
	logic pc_dest_r, pc_dest_nxt, regsh_r, regsh_nxt;

	logic cond_ok;
	logic [3:0] opc, rd, rd_f;
	logic sbit, is_imm, reg_shift, use_saved_program_status, is_dp, is_test, priv;
	logic [2:0] bank;
	logic [31:0] imm_val, src, sel_saved_program_status;
	swtc_class_type cls;

	swtc_cond u_cond (
		.cond(instr[31:28]),
		.flags(current_program_status_r[31:28]),
		.pass(cond_ok)
	);

	// Bank index from the active mode field
	always_comb begin
		case (current_program_status_r[4:0])
			SWTC_M_FIQ: bank = SWTC_BK_FIQ;
			SWTC_M_IRQ: bank = SWTC_BK_IRQ;
			SWTC_M_SVC: bank = SWTC_BK_SVC;
			SWTC_M_ABT: bank = SWTC_BK_ABT;
			SWTC_M_UND: bank = SWTC_BK_UND;
			default: bank = SWTC_BK_NONE;
		endcase
	end

	// Saved word of the current mode, zero where no bank exists
	always_comb begin
		if (bank == SWTC_BK_NONE) begin
			sel_saved_program_status = 32'h00000000;
		end else begin
			sel_saved_program_status = saved_program_status_r[bank];
		end
	end

	// Instruction field split and class decode
	always_comb begin
		opc = instr[24:21];
		sbit = instr[20];
		rd = instr[15:12];
		rd_f = instr[15:12];
		is_imm = instr[25];
		reg_shift = !is_imm && instr[4];
		use_saved_program_status = instr[22];
		is_dp = instr[27:26] == 2'b00 && (is_imm || !(instr[7] && instr[4]));
		is_test = opc[3:2] == 2'b10;
		priv = current_program_status_r[4:0] != SWTC_M_USR;
		imm_val = ({24'h000000, instr[7:0]} >> {instr[11:8], 1'b0})
			| ({24'h000000, instr[7:0]} << (6'h20 - {1'b0, instr[11:8], 1'b0}));
		src = is_imm ? imm_val : operand;
		cls = SWTC_CL_NOP;
		if (instr_valid && !busy_r && is_dp && cond_ok) begin
			if (is_test && sbit) begin
				cls = SWTC_CL_FLAG;
			end else if (is_test && !opc[0] && instr[21:16] == 6'h0f
				&& !is_imm) begin
				cls = SWTC_CL_MRS;
			end else if (is_test && opc[0] && instr[21:16] == 6'h29) begin
				cls = SWTC_CL_MSR_ALL;
			end else if (is_test && opc[0] && instr[21:16] == 6'h28) begin
				cls = SWTC_CL_MSR_FLG;
			end else if (!is_test) begin
				cls = SWTC_CL_DP;
			end
		end
	end

	// Status state, register and PC write requests
	always_comb begin
		current_program_status_nxt = current_program_status_r;
		saved_program_status_nxt = saved_program_status_r;
		rdata_nxt = rdata_r;
		waddr_nxt = waddr_r;
		we_nxt = 1'b0;
		pcwe_nxt = 1'b0;
		pcd_nxt = pcd_r;
		pc_dest_nxt = 1'b0;
		regsh_nxt = 1'b0;
		case (cls)
			SWTC_CL_FLAG: begin
				// Legacy restore form leaves flags alone in user mode
				if (rd_f == SWTC_RD_PC && opc == SWTC_OP_TEQ) begin
					if (priv && bank != SWTC_BK_NONE) begin
						current_program_status_nxt = sel_saved_program_status;
					end
				end else begin
					current_program_status_nxt[31:28] = alu_flags;
				end
				regsh_nxt = reg_shift;
			end
			SWTC_CL_DP: begin
				waddr_nxt = rd;
				regsh_nxt = reg_shift;
				if (rd == SWTC_RD_PC) begin
					pcwe_nxt = 1'b1;
					pcd_nxt = alu_result;
					pc_dest_nxt = 1'b1;
					if (sbit && bank != SWTC_BK_NONE) begin
						current_program_status_nxt = sel_saved_program_status;
					end
				end else begin
					we_nxt = 1'b1;
					rdata_nxt = alu_result;
					if (sbit) begin
						current_program_status_nxt[31:28] = alu_flags;
					end
				end
			end
			SWTC_CL_MRS: begin
				we_nxt = 1'b1;
				waddr_nxt = rd;
				rdata_nxt = use_saved_program_status ? sel_saved_program_status : current_program_status_r;
			end
			SWTC_CL_MSR_ALL: begin
				if (use_saved_program_status) begin
					if (bank != SWTC_BK_NONE) begin
						saved_program_status_nxt[bank] = src & SWTC_DEF_MASK;
					end
				end else if (priv) begin
					current_program_status_nxt = src & SWTC_DEF_MASK;
				end else begin
					current_program_status_nxt[31:28] = src[31:28];
				end
			end
			SWTC_CL_MSR_FLG: begin
				if (use_saved_program_status) begin
					if (bank != SWTC_BK_NONE) begin
						saved_program_status_nxt[bank][31:28] = src[31:28];
					end
				end else begin
					current_program_status_nxt[31:28] = src[31:28];
				end
			end
			default: begin
			end
		endcase
		current_program_status_nxt = current_program_status_nxt & SWTC_DEF_MASK;
	end

	// Incremental cycle sequencing
	always_comb begin
		cyc_nxt = cyc_r;
		pos_nxt = pos_r;
		busy_nxt = busy_r;
		cval_nxt = 1'b0;
		kind_nxt = kind_r;
		saved_program_status_view_nxt = sel_saved_program_status;
		if (!busy_r) begin
			if (cls != SWTC_CL_NOP) begin
				cval_nxt = 1'b1;
				kind_nxt = SWTC_KIND_S;
				case (cls)
					SWTC_CL_MRS, SWTC_CL_MSR_ALL, SWTC_CL_MSR_FLG:
						cyc_nxt = SWTC_CYC_PSR;
					default: begin
						if (cls == SWTC_CL_DP && rd == SWTC_RD_PC) begin
							cyc_nxt = reg_shift ? SWTC_CYC_PC_REGSH
								: SWTC_CYC_PC;
						end else begin
							cyc_nxt = reg_shift ? SWTC_CYC_REGSH
								: SWTC_CYC_NORM;
						end
					end
				endcase
				pos_nxt = 3'h1;
				busy_nxt = cyc_nxt != 3'h1;
			end
		end else begin
			cval_nxt = 1'b1;
			pos_nxt = pos_r + 3'h1;
			busy_nxt = pos_nxt != cyc_r;
			if (regsh_r && pos_r == 3'h1) begin
				kind_nxt = SWTC_KIND_I;
			end else if (pc_dest_r && kind_r != SWTC_KIND_N
				&& pos_nxt == cyc_r - 3'h1) begin
				kind_nxt = SWTC_KIND_N;
			end else begin
				kind_nxt = SWTC_KIND_S;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			current_program_status_r <= SWTC_CURRENT_PROGRAM_STATUS_RST;
			for (int i = 0; i < NBANK; i++) begin
				saved_program_status_r[i] <= SWTC_SAVED_PROGRAM_STATUS_RST;
			end
			rdata_r <= 32'h00000000;
			pcd_r <= 32'h00000000;
			saved_program_status_view_r <= 32'h00000000;
			waddr_r <= 4'h0;
			we_r <= 1'b0;
			pcwe_r <= 1'b0;
			cyc_r <= 3'h0;
			pos_r <= 3'h0;
			kind_r <= SWTC_KIND_S;
			busy_r <= 1'b0;
			ready_r <= 1'b1;
			cval_r <= 1'b0;
			pc_dest_r <= 1'b0;
			regsh_r <= 1'b0;
		end else begin
			current_program_status_r <= current_program_status_nxt;
			saved_program_status_r <= saved_program_status_nxt;
			rdata_r <= rdata_nxt;
			pcd_r <= pcd_nxt;
			saved_program_status_view_r <= saved_program_status_view_nxt;
			waddr_r <= waddr_nxt;
			we_r <= we_nxt;
			pcwe_r <= pcwe_nxt;
			cyc_r <= cyc_nxt;
			pos_r <= pos_nxt;
			kind_r <= kind_nxt;
			busy_r <= busy_nxt;
			ready_r <= !busy_nxt;
			cval_r <= cval_nxt;
			pc_dest_r <= busy_r ? pc_dest_r : pc_dest_nxt;
			regsh_r <= busy_r ? regsh_r : regsh_nxt;
		end
	end

	assign current_status_word = current_program_status_r;
	assign saved_status_word = saved_program_status_view_r;
	assign reg_wdata = rdata_r;
	assign reg_waddr = waddr_r;
	assign reg_we = we_r;
	assign pc_we = pcwe_r;
	assign pc_wdata = pcd_r;
	assign cycle_valid = cval_r;
	assign cycle_kind = swtc_cycle_type'(kind_r);
	assign instr_ready = ready_r;
endmodule

// file: testbench/swtc_core_assertions.sv
`timescale 1ns/1ps
module swtc_core_chk
	import swtc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire logic [31:0] instr,
	input wire logic [31:0] operand,
	input wire logic [3:0] alu_flags,
	input wire logic [31:0] current_status_word,
	input wire logic [31:0] saved_status_word,
	input wire logic [31:0] reg_wdata,
	input wire logic [3:0] reg_waddr,
	input wire logic reg_we,
	input wire logic pc_we,
	input wire logic cycle_valid,
	input wire swtc_cycle_type cycle_kind
);
	logic tk;
	logic [31:0] sw;
	assign sw = current_status_word;
	assign tk = instr_valid && instr_ready && instr[31:28] == 4'he;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	chk_reset_word: assert property (disable iff (1'b0)
		!rstn |=> sw == SWTC_CURRENT_PROGRAM_STATUS_RST) else $error("bad reset word");
	chk_rsvd_zero: assert property (
		((sw | saved_status_word) & ~SWTC_DEF_MASK) == 32'h0)
		else $error("reserved bit set");
	chk_flag_noreg: assert property (tk && instr[27:26] == 2'b00 &&
		instr[24:23] == 2'b10 && instr[20] && instr[15:12] != 4'hf &&
		!(!instr[25] && instr[7] && instr[4])
		|=> !reg_we && sw[31:28] == $past(alu_flags))
		else $error("flag op wrong");
	chk_user_ctl: assert property (tk && sw[4:0] == SWTC_M_USR &&
		instr[27:23] == 5'b00010 && !instr[20]
		|=> sw[7:0] == $past(sw[7:0])) else $error("user control changed");
	chk_msr_flags: assert property (tk && instr[27:12] == 16'h128f
		|=> sw[31:28] == $past(operand[31:28]) && sw[7:0] == $past(sw[7:0]))
		else $error("flag write wrong");
	chk_mrs_data: assert property (tk && instr[27:16] == 12'h10f
		|=> reg_we && reg_wdata == $past(sw) &&
		reg_waddr == $past(instr[15:12])) else $error("status read wrong");
	chk_psr_cycle: assert property (tk && instr[27:23] == 5'b00010 &&
		!instr[20] && instr[21:16] inside {6'h0f, 6'h28, 6'h29}
		|=> cycle_valid && cycle_kind == SWTC_KIND_S)
		else $error("transfer cycle wrong");
	chk_cond_fail: assert property (instr_valid && instr_ready &&
		instr[31:28] == 4'h0 && !sw[30]
		|=> !reg_we && !pc_we && !cycle_valid && $stable(sw))
		else $error("failed condition acted");
	chk_pc_cycles: assert property (tk && instr[27:25] == 3'b001 &&
		instr[24:23] != 2'b10 && instr[15:12] == 4'hf
		|=> pc_we && cycle_valid && cycle_kind == SWTC_KIND_S
		##1 cycle_valid && cycle_kind == SWTC_KIND_N
		##1 cycle_valid && cycle_kind == SWTC_KIND_S)
		else $error("pc write cycles wrong");
endmodule
bind swtc_core swtc_core_chk swtc_core_chk_inst (.*);

// file: testbench/tb_swtc_core.sv
`timescale 1ns/1ps
module tb_swtc_core;
	import swtc_pkg::*;
	logic sys_clk = 0, rstn = 0, instr_valid = 0;
	logic [31:0] instr = 0, operand = 0, alu_result = 0;
	logic [3:0] alu_flags = 0, f;
	logic instr_ready, reg_we, pc_we, cycle_valid;
	logic [31:0] cur, sav, reg_wdata, pc_wdata, lw, s, v;
	logic [3:0] reg_waddr;
	swtc_cycle_type cycle_kind;
	int error_cnt = 0, check_count = 0, seed = 32'h46c7, cyc = 0, nwe;
	int ncyc[3];
	swtc_core swtc_core_inst (.sys_clk(sys_clk), .rstn(rstn),
		.instr_valid(instr_valid), .instr(instr), .operand(operand),
		.alu_flags(alu_flags), .alu_result(alu_result),
		.instr_ready(instr_ready), .current_status_word(cur),
		.saved_status_word(sav), .reg_wdata(reg_wdata),
		.reg_waddr(reg_waddr), .reg_we(reg_we), .pc_we(pc_we),
		.pc_wdata(pc_wdata), .cycle_valid(cycle_valid),
		.cycle_kind(cycle_kind));
	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cycle_valid === 1'b1)
			ncyc[cycle_kind] <= ncyc[cycle_kind] + 1;
		if (reg_we === 1'b1) begin
			nwe <= nwe + 1;
			lw <= reg_wdata;
		end
		if (cyc == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic run(input logic [31:0] i, input logic [31:0] op,
		input logic [3:0] fl);
		int n;
		ncyc = '{0, 0, 0};
		nwe = 0;
		instr <= i;
		operand <= op;
		alu_flags <= fl;
		instr_valid <= 1'b1;
		@(negedge sys_clk);
		instr_valid <= 1'b0;
		n = 0;
		while (instr_ready !== 1'b1 && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		repeat (2) @(negedge sys_clk);
	endtask
	// Status reads put 4'hf in the source field; status writes and PC-target dp calls put it in the destination field
	function automatic logic [31:0] status_read_op(input logic p, input logic [3:0] rd);
		return {4'he, 5'b00010, p, 6'h0f, rd, 12'h0};
	endfunction
	function automatic logic [31:0] status_write_op(input logic p, input logic fl);
		return {4'he, 5'b00010, p, fl ? 6'h28 : 6'h29, 4'hf, 12'h0};
	endfunction
	function automatic logic [31:0] dp(input logic [3:0] op, input logic sb,
		input logic [3:0] rd, input logic im, input logic rs);
		return {4'he, 2'b00, im, op, sb, 4'h1, rd, rs ? 12'h210 : 12'h000};
	endfunction
	initial begin
		repeat (16) @(negedge sys_clk);
		rstn <= 1'b1;
		@(negedge sys_clk);
		check(cur, SWTC_CURRENT_PROGRAM_STATUS_RST);
		v = ($random(seed) & SWTC_FLG_MASK) | 32'h000000d2;
		run(status_write_op(0, 0), v | 32'h0ff00f00, 4'h0);
		check(cur, v);
		s = ($random(seed) & SWTC_FLG_MASK) | 32'h00000013;
		run(status_write_op(1, 0), s | 32'h00ff0000, 4'h0);
		check(sav, s);
		run(status_read_op(1, 4'h3), 32'h0, 4'h0);
		check(lw, s);
		run(status_write_op(0, 0), 32'h000000d1, 4'h0);
		check(sav, SWTC_SAVED_PROGRAM_STATUS_RST);
		run(status_write_op(0, 0), 32'h000000d2, 4'h0);
		check(sav, s);
		for (int k = 0; k < 4; k++) begin
			f = $random(seed);
			run(dp(SWTC_OP_TST + k, 1, 4'h2, 1, 0), 32'h0, f);
			check(cur, {f, 28'h00000d2});
			check(nwe, 0);
			check(ncyc[0], 1);
		end
		run(dp(SWTC_OP_TEQ, 1, 4'hf, 1, 0), 32'h0, 4'h0);
		check(cur, s);
		for (int k = 0; k < 4; k++) begin
			run(dp(4'hd, 0, k[1] ? 4'hf : 4'h1, !k[0], k[0]), 32'h0, 4'h0);
			check(ncyc[0], k[1] ? 2 : 1);
			check(ncyc[1], k[1] ? 1 : 0);
			check(ncyc[2], k[0] ? 1 : 0);
		end
		run(status_write_op(0, 1), 32'h0, 4'h0);
		check(cur, s & 32'h0fffffff);
		run(status_read_op(0, 4'h5), 32'h0, 4'h0);
		check(lw, s & 32'h0fffffff);
		check(ncyc[0], 1);
		run(status_write_op(0, 0) & 32'h0fffffff, 32'h00000010, 4'h0);
		check(cur, s & 32'h0fffffff);
		check(ncyc[0], 0);
		run(status_write_op(1, 0), 32'h400000d2, 4'h0);
		alu_result = $random(seed);
		run(dp(4'hd, 1, 4'hf, 1, 0), 32'h0, 4'h0);
		check(cur, 32'h400000d2);
		check(pc_wdata, alu_result);
		run(status_write_op(0, 0), 32'h00000010, 4'h0);
		run(status_write_op(0, 0), 32'h500000d3, 4'h0);
		check(cur, 32'h50000010);
		run(status_write_op(0, 1), 32'ha0000000, 4'h0);
		check(cur, 32'ha0000010);
		run(dp(SWTC_OP_TEQ, 1, 4'hf, 1, 0), 32'h0, 4'h5);
		check(cur, 32'ha0000010);
		wrap_up();
	end
endmodule
